// *** src/vfd_pkg.sv ***
package vfd_pkg;

    localparam int SLOTS      = 8;
    localparam int INSN_W     = 32;
    localparam int PACKET_W   = SLOTS * INSN_W;
    localparam int REGS       = 16;
    localparam int REG_IDX_W  = 4;
    localparam int UNIT_SEL_W = 3;
    localparam int CHAIN_BIT  = 0;
    localparam int SLOT_IDX_W = 3;

    // unit select field position inside an instruction word
    localparam int UNIT_LSB   = 1;
    // condition field: register index and enable
    localparam int COND_EN    = 28;
    localparam int COND_LSB   = 24;
    localparam int COND_ZERO  = 31;
    // operand fields
    localparam int DST_LSB    = 20;
    localparam int SRC1_LSB   = 16;
    localparam int SRC2_LSB   = 12;
    localparam int XSRC_BIT   = 11;
    localparam int XDST_BIT   = 10;

    // unit select codes; side a occupies 0-3, side b 4-7
    typedef enum logic [UNIT_SEL_W-1:0] {
        UNIT_LOGIC_A   = 3'h0,
        UNIT_SHIFT_A   = 3'h1,
        UNIT_MUL_A     = 3'h2,
        UNIT_DADDR_A   = 3'h3,
        UNIT_LOGIC_B   = 3'h4,
        UNIT_SHIFT_B   = 3'h5,
        UNIT_MUL_B     = 3'h6,
        UNIT_DADDR_B   = 3'h7
    } vfd_unit_t;

    typedef struct packed {
        logic                  valid;
        logic [INSN_W-1:0]     insn;
        logic                  condPass;
        logic [INSN_W-1:0]     src1;
        logic [INSN_W-1:0]     src2;
    } vfd_issue_t;

    typedef struct packed {
        logic                  en;
        logic                  side;
        logic [REG_IDX_W-1:0]  idx;
        logic [INSN_W-1:0]     data;
    } vfd_wb_t;

    typedef enum logic [2:0] {
        ST_FETCH    = 3'h1,
        ST_WAIT     = 3'h2,
        ST_DISPATCH = 3'h4
    } vfd_state_t;

endpackage

// *** src/vfd_regfile.sv ***
`timescale 1ns/1ns
module vfd_regfile
    import vfd_pkg::*;
#(
    parameter int NREG  = REGS,
    parameter int WIDTH = INSN_W,
    parameter int NRD   = 2 * 4 + 2
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        resetn,
    // read ports, all combinational in the same cycle
    input  wire logic [NRD-1:0][REG_IDX_W-1:0] rdIdx,
    output logic      [NRD-1:0][WIDTH-1:0]     rdData,
    // local write ports (one per unit) and one cross write port
    input  wire logic [4:0]                  wrEn,
    input  wire logic [4:0][REG_IDX_W-1:0]   wrIdx,
    input  wire logic [4:0][WIDTH-1:0]       wrData
);

    logic [WIDTH-1:0] regs_q [NREG];

    genvar r;
    generate
        for (r = 0; r < NRD; r++) begin : g_rd
            assign rdData[r] = regs_q[rdIdx[r]];
        end
    endgenerate

    // later port wins if two units target the same register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NREG; i++) regs_q[i] <= '0;
        end else begin
            for (int p = 0; p < 5; p++) begin
                if (wrEn[p]) regs_q[wrIdx[p]] <= wrData[p];
            end
        end
    end

endmodule // vfd_regfile

// *** src/vfd_core.sv ***
`timescale 1ns/1ns
// Behaviour
// RL1: fetch fixed 256-bit packets of eight slots
// RL2: chaining bit one joins next instruction
// RL3: chaining bit zero ends execute packet
// RL4: one to eight instructions issue together
// RL5: one to eight execute packets per fetch
// RL6: at most one execute packet per cycle
// RL7: next fetch only after all dispatched
// RL8: two sides, four units and file each
// RL9: sixteen 32-bit registers per side
// RL10: local file serves all four units
// RL11: one cross read, one cross write
// RL12: only data units reach memory, crosswise
// RL13: linear and circular, 5/15-bit offsets
// RL14: every instruction conditional on a register; code tests it only when COND_EN is set
// RL15: multiply only on multiply units
// RL16: byte, half-word and word memory access
// RL17: provider pads packets, never spans fetches
// RL18: last slot always ends execute packet
// RL19: duplicate unit in packet flags conflict
module vfd_core
    import vfd_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    resetn,
    // program memory
    output logic                         fetchReq,
    output logic [ADDR_W-1:0]            fetchAddr,
    input  wire logic                    fetchValid,
    input  wire logic [PACKET_W-1:0]     fetchData,
    input  wire logic [ADDR_W-1:0]       startAddr,
    // issue to the eight units
    output vfd_issue_t [SLOTS-1:0]       issue,
    output logic                         issueValid,
    output logic                         unitConflict,
    // results back from the units
    input  wire vfd_wb_t [SLOTS-1:0]     unitWb,
    // data address units to memory
    output logic [1:0]                   memReq,
    output logic [1:0]                   memWrite,
    output logic [1:0][1:0]              memSize,
    output logic [1:0]                   memCircular,
    output logic [1:0][ADDR_W-1:0]       memAddr,
    output logic [1:0][INSN_W-1:0]       memWdata
);

    localparam logic [ADDR_W-1:0] FETCH_STEP = ADDR_W'(PACKET_W / 8);
    localparam int SZ_LSB   = 5;
    localparam int CIRC_BIT = 7;
    localparam int LONG_BIT = 8;
    localparam int WR_BIT   = 9;
    localparam int OFS5_W   = 5;
    localparam int OFS15_W  = 15;

    vfd_state_t              state_q, state_d;
    logic [PACKET_W-1:0]     packet_q;
    logic [SLOT_IDX_W:0]     pos_q, pos_d;
    logic [ADDR_W-1:0]       addr_q;
    logic                    started_q;

    // slot views and execute packet boundary
    logic [SLOTS-1:0][INSN_W-1:0] slot;
    logic [SLOTS-1:0]             inPkt;
    logic [SLOTS-1:0]             endsHere;
    logic [SLOT_IDX_W:0]          nextPos;

    assign slot = packet_q; // RL1

    genvar s;
    generate
        for (s = 0; s < SLOTS; s++) begin : g_slot
            // final slot closes the packet whatever its chain bit
            if (s == SLOTS - 1) begin : g_last
                assign endsHere[s] = 1'b1; // RL18
            end else begin : g_mid
                assign endsHere[s] = !slot[s][CHAIN_BIT]; // RL3
            end
        end
    endgenerate

    // a slot belongs to the packet if it is at or after pos and every
    // earlier slot from pos onward chains forward
    always_comb begin
        logic run;
        run = 1'b0;
        nextPos = (SLOT_IDX_W+1)'(SLOTS);
        for (int i = 0; i < SLOTS; i++) begin
            if (i == int'(pos_q)) run = 1'b1;
            inPkt[i] = run; // RL2 RL4
            if (run && endsHere[i]) begin
                if (nextPos == (SLOT_IDX_W+1)'(SLOTS))
                    nextPos = (SLOT_IDX_W+1)'(i + 1);
                run = 1'b0;
            end
        end
    end

    wire dispatching = (state_q == ST_DISPATCH);
    wire lastEp      = (nextPos == (SLOT_IDX_W+1)'(SLOTS)); // RL5

    always_comb begin
        state_d = state_q;
        pos_d   = pos_q;
        case (state_q)
            // hold until the start address is in, else no request goes out
            ST_FETCH: if (started_q) state_d = ST_WAIT; // RL7
            ST_WAIT: if (fetchValid) begin
                state_d = ST_DISPATCH;
                pos_d   = '0;
            end
            ST_DISPATCH: begin
                pos_d = nextPos; // RL6
                if (lastEp) state_d = ST_FETCH; // RL7
            end
            default: state_d = ST_FETCH;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= ST_FETCH;
            pos_q     <= '0;
            started_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            pos_q     <= pos_d;
            started_q <= 1'b1;
        end
    end

    // start address is taken at the first edge after reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_q <= '0;
        end else if (!started_q) begin
            addr_q <= startAddr;
        end else if (state_q == ST_DISPATCH && lastEp) begin
            addr_q <= addr_q + FETCH_STEP;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) packet_q <= '0;
        else if (state_q == ST_WAIT && fetchValid) packet_q <= fetchData;
    end

    assign fetchReq  = (state_q == ST_FETCH) && started_q; // RL7
    assign fetchAddr = addr_q;

    // route each packet slot to the unit it names
    logic [SLOTS-1:0]            unitBusy;
    logic [SLOTS-1:0][INSN_W-1:0] unitInsn;
    logic                         conflict;

    always_comb begin
        logic [UNIT_SEL_W-1:0] u;
        u        = '0;
        unitBusy = '0;
        unitInsn = '0;
        conflict = 1'b0;
        for (int i = 0; i < SLOTS; i++) begin
            if (dispatching && inPkt[i]) begin
                u = slot[i][UNIT_LSB +: UNIT_SEL_W];
                if (unitBusy[u]) conflict = 1'b1; // RL19
                unitBusy[u] = 1'b1;
                unitInsn[u] = unitInsn[u] | slot[i];
            end
        end
    end

    // two register files, four units per side; ports 0-7 serve the local
    // units, 8 the opposite store, 9 the cross read, then one per slot
    // for its condition so every packet member tests in the same cycle
    localparam int CPORT    = 10;
    localparam int RF_PORTS = CPORT + SLOTS;
    logic [1:0][RF_PORTS-1:0][REG_IDX_W-1:0] rdIdx;
    logic [1:0][RF_PORTS-1:0][INSN_W-1:0]    rdData;
    logic [1:0][4:0]                wrEn;
    logic [1:0][4:0][REG_IDX_W-1:0] wrIdx;
    logic [1:0][4:0][INSN_W-1:0]    wrData;
    logic [SLOTS-1:0]               condPass;
    logic [SLOTS-1:0][INSN_W-1:0]   op1, op2;
    logic [1:0][1:0]                xWin;
    logic [1:0][1:0]                xwWin;
    logic [1:0]                     xwAny;

    genvar sd, k;
    generate
        for (sd = 0; sd < 2; sd++) begin : g_side
            vfd_regfile #(.NRD(RF_PORTS)) u_rf ( // RL8 RL9
                .clk    (clk),
                .resetn (resetn),
                .rdIdx  (rdIdx[sd]),
                .rdData (rdData[sd]),
                .wrEn   (wrEn[sd]),
                .wrIdx  (wrIdx[sd]),
                .wrData (wrData[sd])
            );
            for (k = 0; k < 4; k++) begin : g_unit
                localparam int U = sd * 4 + k;
                wire [INSN_W-1:0] w = unitInsn[U];
                // local units read their own file in the same cycle
                assign rdIdx[sd][2*k]   = w[SRC1_LSB +: REG_IDX_W]; // RL10
                assign rdIdx[sd][2*k+1] = w[SRC2_LSB +: REG_IDX_W];
                assign wrEn[sd][k]  = unitWb[U].en
                                      && unitWb[U].side == 1'(sd);
                assign wrIdx[sd][k] = unitWb[U].idx;
                assign wrData[sd][k] = unitWb[U].data;
                assign op1[U] = rdData[sd][2*k];
                // second operand may come over the cross path
                assign op2[U] = (w[XSRC_BIT] && xWin[sd] == 2'(k))
                                ? rdData[1-sd][9] : rdData[sd][2*k+1];
            end
            // store data for the opposite data unit's cross store
            assign rdIdx[sd][8] =
                unitInsn[(1-sd)*4 + 3][SRC2_LSB +: REG_IDX_W];
        end
    endgenerate

    // cross path: first unit per side asking wins, one read per cycle
    always_comb begin
        xWin  = '0;
        xwWin = '0;
        xwAny = '0;
        for (int d = 0; d < 2; d++) begin
            for (int j = 3; j >= 0; j--) begin
                if (unitInsn[d*4+j][XSRC_BIT]) xWin[d] = 2'(j); // RL11
                if (unitWb[d*4+j].en && unitWb[d*4+j].side != 1'(d)) begin
                    xwWin[d] = 2'(j);
                    xwAny[d] = 1'b1;
                end
            end
        end
    end

    generate
        for (sd = 0; sd < 2; sd++) begin : g_cross
            // reader index from the requesting side's winning unit
            assign rdIdx[sd][9] =
                unitInsn[(1-sd)*4 + xWin[1-sd]][SRC2_LSB +: REG_IDX_W];
            // one cross write into this file per cycle
            assign wrEn[sd][4]  = xwAny[1-sd]; // RL11
            assign wrIdx[sd][4] = unitWb[(1-sd)*4 + xwWin[1-sd]].idx;
            assign wrData[sd][4] = unitWb[(1-sd)*4 + xwWin[1-sd]].data;
        end
    endgenerate

    // condition evaluation against the selected file register
    generate
        for (s = 0; s < SLOTS; s++) begin : g_cond
            wire [INSN_W-1:0] w = unitInsn[s];
            // top bit of the field picks the file, the rest the register
            wire [REG_IDX_W-1:0] cIdx = {1'b0, w[COND_LSB +: REG_IDX_W-1]};
            wire [INSN_W-1:0] cv = w[COND_LSB+REG_IDX_W-1] ?
                rdData[1][CPORT+s] : rdData[0][CPORT+s];
            assign rdIdx[0][CPORT+s] = cIdx;
            assign rdIdx[1][CPORT+s] = cIdx;
            // without the enable the condition is implicitly true
            assign condPass[s] = !w[COND_EN] ||
                ((cv != '0) ^ w[COND_ZERO]); // RL14
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            issue        <= '0;
            issueValid   <= 1'b0;
            unitConflict <= 1'b0;
        end else begin
            issueValid   <= dispatching; // RL6
            unitConflict <= conflict;
            for (int u = 0; u < SLOTS; u++) begin
                issue[u].valid    <= unitBusy[u]; // RL4 RL15
                issue[u].insn     <= unitInsn[u];
                issue[u].condPass <= condPass[u];
                issue[u].src1     <= op1[u];
                issue[u].src2     <= op2[u];
            end
        end
    end

    // data address units: only these reach memory; the cross-dest bit
    // lets an address from one file serve data in the other
    generate
        for (sd = 0; sd < 2; sd++) begin : g_mem
            localparam int DU = sd * 4 + 3;
            wire [INSN_W-1:0] w = unitInsn[DU];
            wire [ADDR_W-1:0] ofs = w[LONG_BIT] ?
                ADDR_W'(w[INSN_W-1 -: OFS15_W]) : // RL13
                ADDR_W'(w[INSN_W-1 -: OFS5_W]);
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    memReq[sd]      <= 1'b0;
                    memWrite[sd]    <= 1'b0;
                    memSize[sd]     <= '0;
                    memCircular[sd] <= 1'b0;
                    memAddr[sd]     <= '0;
                    memWdata[sd]    <= '0;
                end else begin
                    memReq[sd]      <= unitBusy[DU] && condPass[DU]; // RL12
                    memWrite[sd]    <= w[WR_BIT];
                    memSize[sd]     <= w[SZ_LSB +: 2]; // RL16
                    memCircular[sd] <= w[CIRC_BIT]; // RL13
                    memAddr[sd]     <= op1[DU] + ofs;
                    memWdata[sd]    <= w[XDST_BIT] ? rdData[1-sd][8]
                                                   : op2[DU]; // RL12
                end
            end
        end
    endgenerate

endmodule // vfd_core

// *** dv/vfd_core_sva.sv ***
`timescale 1ns/1ns
module vfd_core_sva
    import vfd_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  resetn,
    // program memory side
    input wire logic                  fetchReq,
    input wire logic [ADDR_W-1:0]     fetchAddr,
    input wire logic                  fetchValid,
    // issue side
    input wire vfd_issue_t [SLOTS-1:0] issue,
    input wire logic                  issueValid,
    input wire logic                  unitConflict
);
    logic              waiting_q;
    logic              took_q;
    logic              haveAddr_q;
    logic [3:0]        epCount_q;
    logic [ADDR_W-1:0] prevAddr_q;
    logic [SLOTS-1:0]  validMask;
    logic [SLOTS-1:0]  routeOk;
    logic [SLOTS-1:0]  chainZero;
    wire               take = fetchValid && waiting_q;

    for (genvar u = 0; u < SLOTS; u++) begin : g_unit
        assign validMask[u] = issue[u].valid;
        assign routeOk[u]   = !issue[u].valid || issue[u].insn[3:1] == 3'(u);
        assign chainZero[u] = issue[u].valid && !issue[u].insn[CHAIN_BIT];
    end

    // tracks the fetch packet in flight so counts span the whole packet
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waiting_q  <= 1'b0;
            took_q     <= 1'b0;
            haveAddr_q <= 1'b0;
            epCount_q  <= 4'h0;
            prevAddr_q <= '0;
        end else begin
            waiting_q <= fetchReq || (waiting_q && !fetchValid);
            took_q    <= took_q || take;
            epCount_q <= take ? 4'h0 : epCount_q + 4'(issueValid);
            if (fetchReq) begin
                haveAddr_q <= 1'b1;
                prevAddr_q <= fetchAddr;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_fetch_one_cycle: assert property (fetchReq |=> !fetchReq)
        else $error("fetch request longer than one cycle");
    a_wait_quiet: assert property (
        waiting_q |-> !fetchReq && !issueValid)
        else $error("activity while waiting for program memory");
    a_pkt_count: assert property (fetchReq && took_q |->
        (epCount_q + 4'(issueValid)) inside {[4'h1:4'h8]})
        else $error("execute packet count per fetch out of range");
    a_first_issue: assert property (take |-> ##2 issueValid)
        else $error("first execute packet not issued two cycles after fetch");
    a_issue_nonempty: assert property (issueValid |-> validMask != '0)
        else $error("issue pulse with no unit selected");
    a_issue_stands: assert property (!issueValid |-> validMask == '0)
        else $error("unit valid outside issue pulse");
    a_addr_step: assert property (fetchReq && haveAddr_q |->
        fetchAddr == prevAddr_q + ADDR_W'(32))
        else $error("fetch address did not advance by one packet");
    a_unit_route: assert property (issueValid |-> &routeOk)
        else $error("instruction routed to wrong unit");
    a_chain_break: assert property (issueValid |->
        $countones(chainZero) <= 1)
        else $error("execute packet holds more than one chain break");

    c_eight_packets: cover property (issueValid && epCount_q == 4'h7);
    c_full_packet: cover property (issueValid && validMask == 8'hFF);
    c_conflict: cover property (unitConflict);
endmodule // vfd_core_sva

bind vfd_core vfd_core_sva #(.ADDR_W(ADDR_W)) chk_u (
    .clk          (clk),
    .resetn       (resetn),
    .fetchReq     (fetchReq),
    .fetchAddr    (fetchAddr),
    .fetchValid   (fetchValid),
    .issue        (issue),
    .issueValid   (issueValid),
    .unitConflict (unitConflict)
);

// *** dv/vfd_pmem_model.sv ***
`timescale 1ns/1ns
module vfd_pmem_model
    import vfd_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                resetn,
    // fetch port of the core
    input  wire logic                fetchReq,
    input  wire logic [ADDR_W-1:0]   fetchAddr,
    output logic                     fetchValid,
    output logic [PACKET_W-1:0]      fetchData,
    // contents and latency set by the bench
    input  wire logic [PACKET_W-1:0] nextPkt,
    input  wire logic [3:0]          waitCycles,
    output logic [ADDR_W-1:0]        lastAddr
);
    initial begin
        fetchValid = 1'b0;
        fetchData  = '0;
        lastAddr   = '0;
        forever begin
            @(posedge clk);
            if (resetn === 1'b1 && fetchReq === 1'b1) begin
                lastAddr = fetchAddr;
                @(negedge clk);
                repeat (waitCycles) @(negedge clk);
                fetchValid = 1'b1;
                // whole padded packets only, never a split one
                fetchData  = nextPkt;
                @(posedge clk);
                @(negedge clk);
                fetchValid = 1'b0;
                // released data must not look like the packet just taken
                fetchData  = ~nextPkt;
            end
        end
    end
endmodule // vfd_pmem_model

// *** dv/vfd_core_tb_top.sv ***
`timescale 1ns/1ns
module vfd_core_tb_top
    import vfd_pkg::*;
;
    logic                   clk;
    logic                   resetn;
    logic                   fetchReq;
    logic                   fetchValid;
    logic                   issueValid;
    logic                   unitConflict;
    logic [31:0]            fetchAddr;
    logic [31:0]            startAddr;
    logic [31:0]            lastAddr;
    logic [31:0]            expAddr;
    logic [PACKET_W-1:0]    fetchData;
    logic [PACKET_W-1:0]    nextPkt;
    logic [3:0]             waitCycles;
    vfd_issue_t [SLOTS-1:0] issue;
    vfd_wb_t [SLOTS-1:0]    unitWb;
    logic [1:0]             memReq;
    logic [1:0]             memWrite;
    logic [1:0][1:0]        memSize;
    logic [1:0]             memCircular;
    logic [1:0][31:0]       memAddr;
    logic [31:0]            extraBits;
    logic                   expPass;
    int                     bad_count;
    int                     comparisons;

    vfd_core dut_u (.clk(clk), .resetn(resetn), .fetchReq(fetchReq),
        .fetchAddr(fetchAddr), .fetchValid(fetchValid),
        .fetchData(fetchData), .startAddr(startAddr), .issue(issue),
        .issueValid(issueValid), .unitConflict(unitConflict),
        .unitWb(unitWb), .memReq(memReq), .memWrite(memWrite),
        .memSize(memSize), .memCircular(memCircular), .memAddr(memAddr),
        .memWdata());

    vfd_pmem_model mem_u (.clk(clk), .resetn(resetn), .fetchReq(fetchReq),
        .fetchAddr(fetchAddr), .fetchValid(fetchValid),
        .fetchData(fetchData), .nextPkt(nextPkt),
        .waitCycles(waitCycles), .lastAddr(lastAddr));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic compare_val(input logic [31:0] got, input logic [31:0] exp,
                               input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one fetch packet: slot s goes to unit units[3s+:3], chain bit chain[s]
    task automatic run_fetch(input logic [23:0] units, input logic [7:0] chain,
                             input logic [3:0] lat, input logic expConf);
        logic [7:0]  mask [8];
        logic [31:0] ins [8][8];
        logic [31:0] w;
        logic [2:0]  u;
        logic        confSeen;
        int          nEp;
        int          guard;
        nEp = 0;
        confSeen = 1'b0;
        for (int k = 0; k < 8; k++) begin
            mask[k] = 8'h00;
            for (int j = 0; j < 8; j++) ins[k][j] = 32'h0;
        end
        for (int s = 0; s < 8; s++) begin
            u = units[3*s +: 3];
            w = {22'h0, 6'(s), u, chain[s]} | extraBits;
            nextPkt[32*s +: 32] = w;
            mask[nEp][u] = 1'b1;
            ins[nEp][u] = ins[nEp][u] | w;
            if (!chain[s] || s == 7) nEp++;
        end
        waitCycles = lat;
        for (int k = 0; k < nEp; k++) begin
            guard = 0;
            @(negedge clk);
            while (issueValid !== 1'b1 && guard < 40) begin
                confSeen |= (unitConflict === 1'b1);
                @(negedge clk);
                guard++;
            end
            confSeen |= (unitConflict === 1'b1);
            compare_val(32'(issueValid), 32'h1, "issue pulse");
            if (k > 0) compare_val(32'(guard), 32'h0, "packet gap");
            compare_val(32'(memReq),
                32'({mask[k][7], mask[k][3]} & {2{expPass}}), "mem request");
            for (int j = 0; j < 8; j++) begin
                compare_val(32'(issue[j].valid),
                            32'(mask[k][j]), "valid");
                if (mask[k][j]) begin
                    compare_val(issue[j].insn, ins[k][j], "insn");
                    compare_val(32'(issue[j].condPass),
                                32'(expPass), "condition");
                end
            end
        end
        compare_val(32'(confSeen), 32'(expConf), "unit conflict");
        compare_val(lastAddr, expAddr, "fetch address");
        expAddr += 32'h20;
    endtask

    task automatic test_reset_quiet();
        compare_val(32'({fetchReq, issueValid, unitConflict, memReq}), 32'h0,
                    "outputs in reset");
        $display("test reset_quiet done");
    endtask

    task automatic test_singles();
        run_fetch({3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7},
                  8'h00, 4'h0, 1'b0);
        $display("test singles done");
    endtask

    task automatic test_full_chain();
        run_fetch({3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0},
                  8'hFF, 4'h3, 1'b0);
        $display("test full_chain done");
    endtask

    task automatic test_mixed_slow();
        run_fetch({3'h7, 3'h2, 3'h5, 3'h0, 3'h3, 3'h6, 3'h1, 3'h4},
                  8'hB3, 4'h6, 1'b0);
        $display("test mixed_slow done");
    endtask

    task automatic check_mem(input logic [1:0] wr, input logic [31:0] addrA,
                             input logic [31:0] addrB);
        compare_val(32'(memWrite), 32'(wr), "mem write");
        compare_val(32'(memCircular), 32'(wr), "circular");
        compare_val(32'(memSize), 32'h0000_000D, "size");
        compare_val(memAddr[0], addrA, "address a");
        compare_val(memAddr[1], addrB, "address b");
    endtask

    // two packets on all eight units, the second failing its condition; both data units form addresses
    task automatic test_mem();
        extraBits = 32'h9002_0380;
        run_fetch({3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0},
                  8'hFF, 4'h2, 1'b0);
        check_mem(2'h3, 32'h0000_4801, 32'h0000_4801);
        extraBits = 32'h1002_0000;
        expPass = 1'b0;
        run_fetch({3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0},
                  8'hFF, 4'h0, 1'b0);
        check_mem(2'h0, 32'h0000_0002, 32'h0000_0002);
        expPass = 1'b1;
        extraBits = 32'h0;
        $display("test mem done");
    endtask

    // a side b unit writes the first side a register over the cross path
    task automatic test_writeback();
        unitWb[4] = {1'b1, 1'b0, 4'h0, 32'h0000_0005};
        extraBits = 32'h9000_0380;
        expPass = 1'b0;
        run_fetch({3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0},
                  8'hFF, 4'h1, 1'b0);
        check_mem(2'h3, 32'h0000_4805, 32'h0000_4800);
        unitWb = '0;
        expPass = 1'b1;
        extraBits = 32'h0;
        $display("test writeback done");
    endtask

    task automatic test_conflict();
        run_fetch({3'h6, 3'h5, 3'h4, 3'h3, 3'h1, 3'h0, 3'h2, 3'h2},
                  8'h01, 4'h1, 1'b1);
        $display("test conflict done");
    endtask

    initial begin
        resetn = 1'b0;
        nextPkt = '0;
        waitCycles = 4'h0;
        unitWb = '0;
        extraBits = 32'h0;
        expPass = 1'b1;
        startAddr = 32'h0000_1000;
        expAddr = 32'h0000_1000;
        bad_count = 0;
        comparisons = 0;
        repeat (10) @(negedge clk);
        test_reset_quiet();
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        test_singles();
        test_full_chain();
        test_mixed_slow();
        test_mem();
        test_writeback();
        test_conflict();
        wrap_up();
    end

    // the whole run needs well under 200 cycles; this allows a wide margin
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule // vfd_core_tb_top
